// >>> core/modem_pkg.sv
package modem_pkg;

	// Bit timing
	localparam int          CLK_HZ       = 40_000_000;
	localparam int          BAUD         = 9600;
	localparam int          BIT_CYCLES   = CLK_HZ / BAUD;
	localparam int          CNT_W        = 16;

	// Register offsets within the four-byte window
	localparam logic [1:0]  ADDR_DATA    = 2'h0;
	localparam logic [1:0]  ADDR_STATUS  = 2'h1;
	localparam logic [1:0]  ADDR_CTRL    = 2'h2;

	// Control register fields
	localparam int          CTRL_TX_EN   = 0;
	localparam int          CTRL_RX_EN   = 1;
	localparam int          CTRL_HUNT    = 2;
	localparam logic [7:0]  CTRL_MASK    = 8'h03;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;

	// Status register fields
	localparam int          STAT_TX_REQ  = 0;
	localparam int          STAT_RX_RDY  = 1;
	localparam int          STAT_BIT_LK  = 2;
	localparam int          STAT_WORD_LK = 3;

	// Synchronisation
	localparam logic [7:0]  SYNC_WORD    = 8'h7E;
	localparam logic [3:0]  LOCK_EDGES   = 4'h8;
	localparam logic [5:0]  QUIET_BITS   = 6'h20;

	typedef enum logic [1:0] {
		RX_OFF    = 2'b00,
		HUNT_BIT  = 2'b01,
		HUNT_WORD = 2'b10,
		FRAMED    = 2'b11
	} rx_sync_t;

	typedef struct packed {
		logic [7:0] ad;
		logic       ale;
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
	} bus_pins_t;

	localparam bus_pins_t   PINS_IDLE    = 12'h00F;

	typedef struct packed {
		bus_pins_t        pin_s1;
		bus_pins_t        pin_s2;
		bus_pins_t        pin_s3;
		bus_pins_t        pin_f;
		logic             rx_s1;
		logic             rx_s2;
		logic             rx_s3;
		logic             rx_f;
		logic             rx_prev;
		logic [7:0]       addr;
		logic [7:0]       ctrl;
		logic [7:0]       ad_out;
		logic             ad_oe_n;
		logic             int_n;
		logic [7:0]       tx_hold;
		logic             tx_full;
		logic [7:0]       tx_shift;
		logic [2:0]       tx_bit;
		logic [CNT_W-1:0] tx_cnt;
		logic             txd;
		rx_sync_t         rx_state;
		logic [CNT_W-1:0] rx_cnt;
		logic [3:0]       edge_cnt;
		logic [5:0]       quiet;
		logic [7:0]       rx_shift;
		logic [2:0]       rx_bit;
		logic [7:0]       rx_data;
		logic             rx_ready;
	} modem_state_t;

endpackage

// >>> core/sync_serial_modem.sv
`timescale 1ns/1ps
module sync_serial_modem #(
	parameter int BIT_CYCLES = modem_pkg::BIT_CYCLES
) (
	input  wire logic       CLK_I,     // 40 MHz clock
	input  wire logic       RST_N_I,   // Async reset, active low
	input  wire logic [7:0] AD_I,      // Muxed address/data in
	output logic      [7:0] AD_O,      // Read data out
	output logic            AD_OE_N_O, // Low while driving AD
	input  wire logic       ALE_I,     // Address latch strobe
	input  wire logic       CS_N_I,    // Chip select
	input  wire logic       RD_N_I,    // Read strobe
	input  wire logic       WR_N_I,    // Write strobe
	output logic            INT_N_O,   // Interrupt request
	output logic            TXD_O,     // Serial transmit data
	input  wire logic       RXD_I      // Serial receive data
);

	localparam logic [modem_pkg::CNT_W-1:0] BIT_LAST = modem_pkg::CNT_W'(BIT_CYCLES - 1);
	localparam logic [modem_pkg::CNT_W-1:0] BIT_HALF = modem_pkg::CNT_W'(BIT_CYCLES / 2);

	modem_pkg::modem_state_t s;
	modem_pkg::modem_state_t next_s;
	modem_pkg::bus_pins_t    pins_in;

	logic       cs;
	logic       wr_done;
	logic       rd_done;
	logic       edge_seen;
	logic       sample;
	logic       tx_req;
	logic [7:0] rd_val;
	logic [7:0] status;

	assign pins_in = {AD_I, ALE_I, CS_N_I, RD_N_I, WR_N_I};

	always_comb
	begin
		next_s = s;
		// Three-stage pin synchronisers; filtered value moves when stages 2 and 3 agree
		next_s.pin_s1  = pins_in;
		next_s.pin_s2  = s.pin_s1;
		next_s.pin_s3  = s.pin_s2;
		next_s.pin_f   = (s.pin_f & (s.pin_s2 ^ s.pin_s3)) | (s.pin_s2 & ~(s.pin_s2 ^ s.pin_s3));
		next_s.rx_s1   = RXD_I;
		next_s.rx_s2   = s.rx_s1;
		next_s.rx_s3   = s.rx_s2;
		next_s.rx_f    = (s.rx_s2 == s.rx_s3) ? s.rx_s2 : s.rx_f;
		next_s.rx_prev = s.rx_f;

		cs      = ~s.pin_f.cs_n;
		wr_done = cs & ~s.pin_f.wr_n & next_s.pin_f.wr_n;
		rd_done = cs & ~s.pin_f.rd_n & next_s.pin_f.rd_n;

		// Address phase
		if (s.pin_f.ale)
		begin
			next_s.addr = s.pin_f.ad;
		end

		// Transmit bit clock and shifter, MSB first
		if (s.tx_cnt == BIT_LAST)
		begin
			next_s.tx_cnt = '0;
			if (s.tx_bit == 3'h7)
			begin
				next_s.tx_bit   = 3'h0;
				// Empty holding register sends sync fill to keep the stream continuous
				next_s.tx_shift = s.tx_full ? s.tx_hold : modem_pkg::SYNC_WORD;
				next_s.tx_full  = 1'b0;
			end
			else
			begin
				next_s.tx_bit   = s.tx_bit + 3'h1;
				next_s.tx_shift = {s.tx_shift[6:0], 1'b0};
			end
		end
		else
		begin
			next_s.tx_cnt = s.tx_cnt + 1'b1;
		end
		// Output moves only on bit boundaries, so enabling never cuts a bit short
		if (s.tx_cnt == BIT_LAST)
		begin
			next_s.txd = s.ctrl[modem_pkg::CTRL_TX_EN] ? next_s.tx_shift[7] : 1'b1;
		end

		// Host writes; a load in the same cycle used the old byte
		if (wr_done)
		begin
			case (s.addr[1:0])
				modem_pkg::ADDR_DATA:
				begin
					next_s.tx_hold = s.pin_f.ad;
					next_s.tx_full = 1'b1;
				end
				modem_pkg::ADDR_CTRL:
				begin
					next_s.ctrl = s.pin_f.ad & modem_pkg::CTRL_MASK;
					if (s.pin_f.ad[modem_pkg::CTRL_HUNT] && s.rx_state == modem_pkg::FRAMED)
					begin
						next_s.rx_state = modem_pkg::HUNT_WORD;
					end
				end
				default:
				begin
				end
			endcase
		end

		// Reading the received byte services the request; a new byte still wins
		if (rd_done && s.addr[1:0] == modem_pkg::ADDR_DATA)
		begin
			next_s.rx_ready = 1'b0;
		end

		// Receive bit synchroniser
		edge_seen = s.rx_f ^ s.rx_prev;
		sample    = 1'b0;
		if (!s.ctrl[modem_pkg::CTRL_RX_EN])
		begin
			next_s.rx_state = modem_pkg::RX_OFF;
			next_s.rx_cnt   = '0;
			next_s.edge_cnt = 4'h0;
			next_s.quiet    = 6'h00;
			next_s.rx_bit   = 3'h0;
		end
		else
		begin
			if (edge_seen)
			begin
				// Realign the sample point to mid-bit on every transition
				next_s.rx_cnt = '0;
				next_s.quiet  = 6'h00;
				if (s.edge_cnt != modem_pkg::LOCK_EDGES)
				begin
					next_s.edge_cnt = s.edge_cnt + 4'h1;
				end
			end
			else if (s.rx_cnt == BIT_LAST)
			begin
				next_s.rx_cnt = '0;
			end
			else
			begin
				next_s.rx_cnt = s.rx_cnt + 1'b1;
			end

			sample = ~edge_seen & (s.rx_cnt == BIT_HALF);
			if (sample)
			begin
				next_s.rx_shift = {s.rx_shift[6:0], s.rx_f};
				if (s.quiet != modem_pkg::QUIET_BITS)
				begin
					next_s.quiet = s.quiet + 6'h01;
				end
			end

			case (s.rx_state)
				modem_pkg::RX_OFF:
				begin
					next_s.rx_state = modem_pkg::HUNT_BIT;
				end
				modem_pkg::HUNT_BIT:
				begin
					if (s.edge_cnt == modem_pkg::LOCK_EDGES)
					begin
						next_s.rx_state = modem_pkg::HUNT_WORD;
					end
				end
				modem_pkg::HUNT_WORD:
				begin
					if (sample && next_s.rx_shift == modem_pkg::SYNC_WORD)
					begin
						next_s.rx_state = modem_pkg::FRAMED;
						next_s.rx_bit   = 3'h0;
					end
				end
				modem_pkg::FRAMED:
				begin
					if (sample)
					begin
						next_s.rx_bit = s.rx_bit + 3'h1;
						if (s.rx_bit == 3'h7)
						begin
							next_s.rx_data  = next_s.rx_shift;
							next_s.rx_ready = 1'b1;
						end
					end
				end
				default:
				begin
					next_s.rx_state = modem_pkg::HUNT_BIT;
				end
			endcase

			// Line gone quiet: bit lock is lost
			if (s.quiet == modem_pkg::QUIET_BITS && s.rx_state != modem_pkg::RX_OFF)
			begin
				next_s.rx_state = modem_pkg::HUNT_BIT;
				next_s.edge_cnt = 4'h0;
				next_s.quiet    = 6'h00;
			end
		end

		// Read path
		tx_req = s.ctrl[modem_pkg::CTRL_TX_EN] & ~s.tx_full;
		status = 8'h00;
		status[modem_pkg::STAT_TX_REQ]  = tx_req;
		status[modem_pkg::STAT_RX_RDY]  = s.rx_ready;
		status[modem_pkg::STAT_BIT_LK]  = s.rx_state[1];
		status[modem_pkg::STAT_WORD_LK] = (s.rx_state == modem_pkg::FRAMED);
		case (s.addr[1:0])
			modem_pkg::ADDR_DATA:   rd_val = s.rx_data;
			modem_pkg::ADDR_STATUS: rd_val = status;
			modem_pkg::ADDR_CTRL:   rd_val = s.ctrl;
			default:                rd_val = 8'h00;
		endcase
		next_s.ad_out  = rd_val;
		next_s.ad_oe_n = ~(cs & ~s.pin_f.rd_n);

		// Interrupt level from the serviced flags
		next_s.int_n = ~((next_s.ctrl[modem_pkg::CTRL_TX_EN] & ~next_s.tx_full) | next_s.rx_ready);
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			s          <= '0;
			s.pin_s1   <= modem_pkg::PINS_IDLE;
			s.pin_s2   <= modem_pkg::PINS_IDLE;
			s.pin_s3   <= modem_pkg::PINS_IDLE;
			s.pin_f    <= modem_pkg::PINS_IDLE;
			s.rx_s1    <= 1'b1;
			s.rx_s2    <= 1'b1;
			s.rx_s3    <= 1'b1;
			s.rx_f     <= 1'b1;
			s.rx_prev  <= 1'b1;
			s.ctrl     <= modem_pkg::CTRL_RESET;
			s.ad_oe_n  <= 1'b1;
			s.int_n    <= 1'b1;
			s.tx_shift <= modem_pkg::SYNC_WORD;
			s.txd      <= 1'b1;
			s.rx_state <= modem_pkg::RX_OFF;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign AD_O      = s.ad_out;
	assign AD_OE_N_O = s.ad_oe_n;
	assign INT_N_O   = s.int_n;
	assign TXD_O     = s.txd;

endmodule

// >>> tb/sync_serial_modem_checker.sv
`timescale 1ns/1ps
module sync_serial_modem_checker (
	input wire logic CLK_I,     // Clock
	input wire logic RST_N_I,   // Reset
	input wire logic CS_N_I,    // Select
	input wire logic RD_N_I,    // Read
	input wire logic AD_OE_N_O, // Bus drive
	input wire logic INT_N_O,   // Interrupt
	input wire logic TXD_O      // Serial out
);
	logic [4:0] idle;
	// Cycles since the host last selected the device
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			idle <= 5'h00;
		else if (!CS_N_I)
			idle <= 5'h00;
		else if (idle != 5'h1F)
			idle <= idle + 5'h01;
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	AST_RESET_IDLE:
		assert property ($rose(RST_N_I) |-> INT_N_O && TXD_O && AD_OE_N_O) else $error("outputs not idle");
	AST_OE_FALL:
		assert property ($fell(AD_OE_N_O) |-> !$past(CS_N_I, 3) && !$past(RD_N_I, 3)) else $error("drive without read");
	AST_OE_RELEASE:
		assert property ($rose(RD_N_I) |-> ##[1:8] AD_OE_N_O) else $error("bus not released");
	AST_OE_ONLY_READ:
		assert property (!AD_OE_N_O |-> !(RD_N_I && $past(RD_N_I, 8))) else $error("bus driven idle");
	AST_TXD_HOLD:
		assert property ($changed(TXD_O) |=> $stable(TXD_O) [*8]) else $error("short serial bit");
	AST_INT_HOLD:
		assert property (!INT_N_O && idle > 5'h10 |=> !INT_N_O) else $error("interrupt dropped unserviced");
	AST_INT_RISE:
		assert property ($rose(INT_N_O) |-> idle < 5'h10) else $error("interrupt cleared without access");
endmodule

// >>> tb/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
	input  wire logic           clk_i,  // Bus clock
	input  wire logic [7:0]     ad_i,   // Bus level
	output modem_pkg::bus_pins_t pins_o // Host pins
);
	initial pins_o = modem_pkg::PINS_IDLE;
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	// Address on the latch strobe, then one strobe
	task automatic xfer(input logic [1:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		step(1);
		pins_o.ad = {6'h00, a};
		pins_o.ale = 1'h1;
		step(8);
		pins_o.ale = 1'h0;
		step(1);
		pins_o.ad = d;
		pins_o.cs_n = 1'h0;
		pins_o.wr_n = !w;
		pins_o.rd_n = w;
		step(9);
		q = ad_i;
		step(1);
		pins_o.wr_n = 1'h1;
		pins_o.rd_n = 1'h1;
		step(1);
		pins_o.cs_n = 1'h1;
		pins_o.ad = ~d;
		step(7);
	endtask
endmodule

// >>> tb/test_sync_serial_modem.sv
`timescale 1ns/1ps
module test_sync_serial_modem;
	localparam int BITS = 40;
	logic                 clk = 1'h0;
	logic                 rst_n = 1'h0;
	logic [31:0]          seed = 32'h0000_0035;
	logic [7:0]           q;
	logic [7:0]           b;
	logic                 int_rose = 1'h0;
	int                   fails = 0;
	int                   comparisons = 0;
	int                   cycles = 0;
	modem_pkg::bus_pins_t pins;
	wire logic [7:0]      ad_o;
	wire logic            oe_n;
	wire logic            int_n;
	wire logic            txd;
	wire logic [7:0]      ad = oe_n ? pins.ad : ad_o;
	always #12.5 clk = ~clk;
	// Serial far end loops transmit back to receive
	sync_serial_modem #(.BIT_CYCLES(BITS)) uut (.CLK_I(clk), .RST_N_I(rst_n), .AD_I(ad), .AD_O(ad_o),
		.AD_OE_N_O(oe_n), .ALE_I(pins.ale), .CS_N_I(pins.cs_n), .RD_N_I(pins.rd_n), .WR_N_I(pins.wr_n),
		.INT_N_O(int_n), .TXD_O(txd), .RXD_I(txd));
	host_bus_model host (.clk_i(clk), .ad_i(ad), .pins_o(pins));
	function automatic logic [7:0] next_byte();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return (seed[7:0] == modem_pkg::SYNC_WORD) ? 8'h81 : seed[7:0];
	endfunction
	task automatic check(input string name, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, e, s);
		end
	endtask
	task automatic print_verdict();
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			fails++;
			print_verdict();
		end
	end
	always @(posedge int_n) int_rose = 1'h1;
	initial
	begin
		repeat (2) @(posedge clk);
		#2;
		rst_n = 1'h1;
		host.step(6);
		check("int_n", 8'h01, {7'h00, int_n});
		check("txd", 8'h01, {7'h00, txd});
		host.xfer(modem_pkg::ADDR_CTRL, 1'h1, 8'h01, q);
		host.step(4);
		check("int_n", 8'h00, {7'h00, int_n});
		int_rose = 1'h0;
		host.xfer(modem_pkg::ADDR_DATA, 1'h1, next_byte(), q);
		check("int_rose", 8'h01, {7'h00, int_rose});
		host.xfer(2'h3, 1'h0, 8'h00, q);
		check("reserved", 8'h00, q);
		host.xfer(modem_pkg::ADDR_CTRL, 1'h1, 8'h03, q);
		host.step(32 * 8 * BITS);
		host.xfer(modem_pkg::ADDR_STATUS, 1'h0, 8'h00, q);
		check("word_lock", 8'h01, {7'h00, q[modem_pkg::STAT_WORD_LK]});
		// Re-hunt just after a byte boundary; word lock must drop (bit lock held) until the next aligned sync word
		host.xfer(modem_pkg::ADDR_DATA, 1'h0, 8'h00, q);
		q = 8'h00;
		for (int n = 0; n < 20 && !q[modem_pkg::STAT_RX_RDY]; n++)
		begin
			host.xfer(modem_pkg::ADDR_STATUS, 1'h0, 8'h00, q);
		end
		host.xfer(modem_pkg::ADDR_DATA, 1'h0, 8'h00, q);
		host.xfer(modem_pkg::ADDR_CTRL, 1'h1, 8'h07, q);
		host.xfer(modem_pkg::ADDR_STATUS, 1'h0, 8'h00, q);
		check("hunt_status", 8'h04, q & 8'h0C);
		host.xfer(modem_pkg::ADDR_CTRL, 1'h0, 8'h00, q);
		check("ctrl", 8'h03, q);
		for (int k = 0; k < 6; k++)
		begin
			b = next_byte();
			host.xfer(modem_pkg::ADDR_DATA, 1'h1, b, q);
			q = modem_pkg::SYNC_WORD;
			for (int n = 0; n < 60 && q === modem_pkg::SYNC_WORD; n++)
			begin
				host.xfer(modem_pkg::ADDR_STATUS, 1'h0, 8'h00, q);
				if (q[modem_pkg::STAT_RX_RDY])
					host.xfer(modem_pkg::ADDR_DATA, 1'h0, 8'h00, q);
				else
					q = modem_pkg::SYNC_WORD;
			end
			check("rx_byte", b, q);
		end
		print_verdict();
	end
endmodule
bind sync_serial_modem sync_serial_modem_checker checker_i (.CLK_I, .RST_N_I, .CS_N_I, .RD_N_I, .AD_OE_N_O,
	.INT_N_O, .TXD_O);
